// ===== logic/bus_seq.sv
// bus cycle sequencer: retry, bus error, dynamic sizing, burst fetch
// assumes one clock; pin inputs are synchronised here, core side is not
//
// How it works
// - retry sampled at end of transfer state
// - retried cycle finishes, data dropped, restarts later
// - retry repeats only failed part, finishes burst
// - outputs float while retry low, then restart
// - bus error sampled at end of transfer
// - error on needed reference raises exception
// - error in ack or return read halts
// - only final wait state samples count
// - retry wins over simultaneous bus error
// - error in transfer: finish, drop data, ignore
// - width taken from final second state only
// - narrow width: two idles once per operand
// - width codes: reserved, 8, 16, 32 bits
// - operands split into aligned double-word parts
// - each transaction starts assuming 32-bit bus
// - narrow cycle: ignore accept, drop burst request
// - fetch address exact or aligned, distinct status
// - fetches enable all lanes, request burst unless in the last double-word of the block
// - 32-bit burst fetches up to three more
`timescale 1ns/1ps
`include "bus_seq_defines.svh"

module bus_seq #(
	parameter int BUF_DEPTH = 2
) (
	// clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    srst,
	// operand requests from the core
	input  wire logic                    req_valid,
	output logic                         req_ready,
	input  wire bus_seq_pkg::op_req_type req,
	// answer words to the core
	output logic                         rsp_valid,
	input  wire logic                    rsp_ready,
	output bus_seq_pkg::op_rsp_type      rsp,
	// events to the core
	output logic                         bus_error_exception,
	output logic                         halted,
	// address, data and control pins
	output logic [31:0]                  address_out,
	output logic                         address_oe,
	output logic [31:0]                  data_out,
	output logic                         data_oe,
	input  wire logic [31:0]             data_in,
	output logic [3:0]                   byte_enable_n,
	output logic [4:0]                   cycle_status_code,
	output logic                         bus_cycle_start_n,
	output logic                         write_n,
	output logic                         burst_request_out_n,
	output logic                         control_oe,
	// answer pins from memory
	input  wire logic                    bus_ready_n,
	input  wire logic                    bus_retry_n,
	input  wire logic                    bus_error_n,
	input  wire logic                    width_select_low,
	input  wire logic                    width_select_high,
	input  wire logic                    burst_accept_in_n
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	bus_seq_pkg::seq_state_type state_r, state_nxt;	// sequencer state
	bus_seq_pkg::seq_state_type after_r, after_nxt;	// state after a gap
	bus_seq_pkg::op_req_type    op_r, op_nxt;		// operand in flight
	bus_seq_pkg::bus_in_type    pin_meta_r;		// first sync stage
	bus_seq_pkg::bus_in_type    pin_r;			// synchronised pins
	logic [31:0] addr_r, addr_nxt;		// address of current cycle
	logic [3:0]  lanes_r, lanes_nxt;	// byte enables of this part
	logic [3:0]  hi_lanes_r, hi_lanes_nxt;	// byte enables of second part
	logic [3:0]  need_r, need_nxt;		// lanes still to move
	logic [31:0] wdat_r, wdat_nxt;		// write data of this part
	logic [31:0] whi_r, whi_nxt;		// write data of second part
	logic [31:0] acc_r, acc_nxt;		// narrow read assembly
	logic [31:0] dout_r, dout_nxt;		// data pins, mirrored low
	logic        part_r, part_nxt;		// second part under way
	logic        two_r, two_nxt;		// operand has two parts
	logic [1:0]  beats_r, beats_nxt;	// burst beats left
	logic        burst_r, burst_nxt;	// burst request active
	logic        narrow_r, narrow_nxt;	// idles already inserted
	logic        err_r, err_nxt;		// error seen in operand
	logic [1:0]  gap_r, gap_nxt;		// idle cycles left
	logic        exc_r, exc_nxt;		// exception pulse

	// ----------------------------------------
	// decode of the current cycle
	// ----------------------------------------
	wire        is_fetch   = (op_r.kind == bus_seq_pkg::OP_FETCH_NONSEQ) ||
	                         (op_r.kind == bus_seq_pkg::OP_FETCH_SEQ);
	wire        is_write   = (op_r.kind == bus_seq_pkg::OP_WRITE);
	wire        in_xfer    = (state_r == bus_seq_pkg::ST_XFER);
	wire        in_burst   = (state_r == bus_seq_pkg::ST_BURST);
	// end of the last wait state: only this cycle's samples count
	wire        sample     = (in_xfer || in_burst) && !pin_r.ready_n;
	wire        retry_hit  = sample && !pin_r.retry_n;
	// retry masks the error; repeat errors in one operand are ignored
	wire        err_hit    = sample && pin_r.retry_n && !pin_r.error_n && !err_r;
	wire [1:0]  wcode_pin  = {pin_r.width_high, pin_r.width_low};
	// width only from the second state; burst beats and reserved are 32
	wire [1:0]  wcode      = (in_xfer && wcode_pin != `WIDTH_CODE_RSVD) ?
	                         wcode_pin : `WIDTH_CODE_32;
	wire        narrow     = (wcode != `WIDTH_CODE_32);
	wire        is8        = (wcode == `WIDTH_CODE_8);
	// lanes moved by this cycle on the sampled width
	wire [3:0]  cov        = !narrow ? `ALL_LANES :
	                         is8 ? (4'h1 << addr_r[1:0]) :
	                         (addr_r[1] ? 4'hC : 4'h3);
	wire [3:0]  need_left  = need_r & ~cov;
	wire        part_done  = sample && !retry_hit && (need_left == 4'h0);
	wire        buf_ready;
	wire        buf_valid;
	// burst goes on only with room for the next word
	wire        burst_go   = part_done && !narrow && burst_r && !pin_r.accept_n &&
	                         (beats_r != 2'h0) && (!buf_valid || rsp_ready);
	wire        op_last    = part_done && !burst_go && (part_r || !two_r);
	wire [31:0] merged     = !narrow ? pin_r.data :
	                         merge(acc_r, pin_r.data, addr_r[1:0], is8);
	wire        fatal      = err_hit && op_r.fatal_ctx;
	wire        push       = part_done && !fatal;
	bus_seq_pkg::op_rsp_type push_word;

	// ----------------------------------------
	// operand split of an incoming request
	// ----------------------------------------
	wire        req_fetch  = (req.kind == bus_seq_pkg::OP_FETCH_NONSEQ) ||
	                         (req.kind == bus_seq_pkg::OP_FETCH_SEQ);
	wire [3:0]  size_mask  = 4'((5'h1 << req.size) - 5'h1);
	wire [7:0]  lanes8     = {4'h0, size_mask} << req.addr[1:0];
	wire [63:0] data64     = {32'h0, req.wdata} << {req.addr[1:0], 3'h0};
	// double-word units, crossing operands take a second part
	wire        req_two    = !req_fetch && (lanes8[7:4] != 4'h0);
	// sequential fetches show the aligned double-word address
	wire [31:0] req_addr   = (req.kind == bus_seq_pkg::OP_FETCH_SEQ) ?
	                         {req.addr[31:2], 2'h0} : req.addr;
	wire        req_whole  = req_fetch || (req.cacheable && req.kind == bus_seq_pkg::OP_READ);
	wire [3:0]  req_lanes  = req_fetch ? `ALL_LANES : lanes8[3:0];

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// place a narrow read into its lanes of the assembly word
	function automatic [31:0] merge(input [31:0] acc, input [31:0] d,
	                                input [1:0] a, input b8);
		logic [31:0] r;
		r = acc;
		if (b8) begin
			r[8*a +: 8] = d[7:0];
		end else begin
			r[16*a[1] +: 16] = d[15:0];
		end
		return r;
	endfunction : merge

	// next lane still needed, searching upward with wrap
	function automatic [1:0] next_lane(input [3:0] need, input [1:0] cur,
	                                   input b8);
		logic [1:0] r;
		logic [1:0] l;
		r = cur;
		for (int i = 3; i >= 1; i--) begin
			l = 2'(cur + 2'(i));
			if (need[l]) begin
				r = l;
			end
		end
		return b8 ? r : {r[1], 1'b0};
	endfunction : next_lane

	// copy the addressed half and byte onto the low lanes
	function automatic [31:0] mirror(input [31:0] d, input [1:0] a);
		logic [15:0] lo;
		lo = a[1] ? d[31:16] : d[15:0];
		return {d[31:16], lo[15:8], a[0] ? lo[15:8] : lo[7:0]};
	endfunction : mirror

	// burst eligibility of a double-word at a given address
	function automatic logic burst_ok(input logic whole, input [31:0] a);
		return whole && (a[3:2] != `LAST_DWORD_OF_BLOCK);
	endfunction : burst_ok

	// ----------------------------------------
	// pin synchroniser, two stages
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		pin_meta_r <= {bus_retry_n, bus_error_n, width_select_high, width_select_low,
		               burst_accept_in_n, bus_ready_n, data_in};
		pin_r      <= pin_meta_r;
	end

	// ----------------------------------------
	// answer buffer
	// ----------------------------------------
	always_comb begin
		push_word.addr  = {addr_r[31:2], 2'h0};
		// discarded data after an error
		push_word.data  = (err_r || err_hit) ? 32'h0 : merged;
		push_word.error = err_r || err_hit;
		push_word.last  = op_last;
	end

	word_buffer #(
		.WIDTH ($bits(bus_seq_pkg::op_rsp_type)),
		.DEPTH (BUF_DEPTH)
	) u_rsp_buffer (
		.core_clk  (core_clk),
		.srst      (srst),
		.in_valid  (push),
		.in_ready  (buf_ready),
		.in_data   (push_word),
		.out_valid (buf_valid),
		.out_ready (rsp_ready),
		.out_data  (rsp)
	);

	assign rsp_valid = buf_valid;
	assign req_ready = (state_r == bus_seq_pkg::ST_IDLE) && buf_ready;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		state_nxt    = state_r;
		after_nxt    = after_r;
		op_nxt       = op_r;
		addr_nxt     = addr_r;
		lanes_nxt    = lanes_r;
		hi_lanes_nxt = hi_lanes_r;
		need_nxt     = need_r;
		wdat_nxt     = wdat_r;
		whi_nxt      = whi_r;
		acc_nxt      = acc_r;
		part_nxt     = part_r;
		two_nxt      = two_r;
		beats_nxt    = beats_r;
		burst_nxt    = burst_r;
		narrow_nxt   = narrow_r;
		err_nxt      = err_r;
		gap_nxt      = gap_r;
		exc_nxt      = 1'b0;
		unique case (state_r)
			// take an operand and set up its first part
			bus_seq_pkg::ST_IDLE: begin
				if (req_valid && buf_ready) begin
					op_nxt       = req;
					addr_nxt     = req_addr;
					lanes_nxt    = req_lanes;
					hi_lanes_nxt = lanes8[7:4];
					need_nxt     = req_whole ? `ALL_LANES : req_lanes;
					wdat_nxt     = data64[31:0];
					whi_nxt      = data64[63:32];
					two_nxt      = req_two;
					part_nxt     = 1'b0;
					acc_nxt      = 32'h0;
					err_nxt      = 1'b0;
					narrow_nxt   = 1'b0;
					beats_nxt    = 2'(`BURST_BEATS_MAX - req_addr[3:2]);
					state_nxt    = bus_seq_pkg::ST_ADDR;
				end
			end
			// address state: burst request decided for this double-word
			bus_seq_pkg::ST_ADDR: begin
				burst_nxt = burst_ok(is_fetch || (op_r.cacheable && !is_write), addr_r);
				state_nxt = bus_seq_pkg::ST_XFER;
			end
			// transfer and burst states end only on ready
			bus_seq_pkg::ST_XFER, bus_seq_pkg::ST_BURST: begin
				if (retry_hit) begin
					// failed cycle finishes, nothing kept, same address again
					burst_nxt = 1'b0;
					state_nxt = bus_seq_pkg::ST_HOLD;
				end else if (fatal) begin
					state_nxt = bus_seq_pkg::ST_HALT;
				end else if (sample) begin
					err_nxt = err_r || err_hit;
					acc_nxt = merged;
					need_nxt = need_left;
					if (narrow) begin
						burst_nxt = 1'b0;
					end
					if (burst_go) begin
						// next consecutive double-word of the block
						addr_nxt  = {addr_r[31:4], 2'(addr_r[3:2] + 2'h1), 2'h0};
						beats_nxt = 2'(beats_r - 2'h1);
						burst_nxt = burst_ok(1'b1, {addr_r[31:4],
						            2'(addr_r[3:2] + 2'h1), 2'h0});
						state_nxt = bus_seq_pkg::ST_BURST;
					end else if (!part_done) begin
						// another narrow cycle for the remaining lanes
						addr_nxt  = {addr_r[31:2], next_lane(need_r & ~cov,
						             addr_r[1:0], is8)};
						state_nxt = bus_seq_pkg::ST_ADDR;
					end else if (!op_last) begin
						// second double-word part of a split operand
						part_nxt  = 1'b1;
						addr_nxt  = {30'(addr_r[31:2] + 30'h1), 2'h0};
						lanes_nxt = hi_lanes_r;
						need_nxt  = hi_lanes_r;
						wdat_nxt  = whi_r;
						acc_nxt   = 32'h0;
						after_nxt = bus_seq_pkg::ST_ADDR;
						gap_nxt   = 2'h0;
						state_nxt = bus_seq_pkg::ST_GAP;
					end else begin
						exc_nxt   = (err_r || err_hit) && op_r.needed;
						after_nxt = bus_seq_pkg::ST_IDLE;
						gap_nxt   = 2'h0;
						state_nxt = bus_seq_pkg::ST_GAP;
					end
					// first narrow cycle of the operand: two idle states
					if (narrow && !narrow_r) begin
						narrow_nxt = 1'b1;
						gap_nxt    = 2'(`NARROW_IDLE_CYCLES - 2'h1);
						after_nxt  = (state_nxt == bus_seq_pkg::ST_GAP) ?
						             after_nxt : state_nxt;
						state_nxt  = bus_seq_pkg::ST_GAP;
					end
				end
			end
			// bus floated until retry is released
			bus_seq_pkg::ST_HOLD: begin
				if (pin_r.retry_n) begin
					gap_nxt   = 2'(`RETRY_RESTART_CYCLES - 2'h1);
					after_nxt = bus_seq_pkg::ST_ADDR;
					state_nxt = bus_seq_pkg::ST_GAP;
				end
			end
			// idle states, then onward once the buffer has room
			bus_seq_pkg::ST_GAP: begin
				if (gap_r != 2'h0) begin
					gap_nxt = 2'(gap_r - 2'h1);
				end else if (buf_ready) begin
					state_nxt = after_r;
				end
			end
			// stays until reset
			bus_seq_pkg::ST_HALT: begin
				state_nxt = bus_seq_pkg::ST_HALT;
			end
			default: begin
				state_nxt = bus_seq_pkg::ST_IDLE;
			end
		endcase
		dout_nxt = mirror(wdat_nxt, addr_nxt[1:0]);
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= bus_seq_pkg::ST_IDLE;
			after_r <= bus_seq_pkg::ST_IDLE;
			gap_r   <= 2'h0;
			burst_r <= 1'b0;
			exc_r   <= 1'b0;
			err_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			after_r <= after_nxt;
			gap_r   <= gap_nxt;
			burst_r <= burst_nxt;
			exc_r   <= exc_nxt;
			err_r   <= err_nxt;
		end
	end

	// operand and address registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			op_r       <= '0;
			addr_r     <= 32'h0;
			lanes_r    <= 4'h0;
			hi_lanes_r <= 4'h0;
			need_r     <= 4'h0;
			part_r     <= 1'b0;
			two_r      <= 1'b0;
			beats_r    <= 2'h0;
			narrow_r   <= 1'b0;
		end else begin
			op_r       <= op_nxt;
			addr_r     <= addr_nxt;
			lanes_r    <= lanes_nxt;
			hi_lanes_r <= hi_lanes_nxt;
			need_r     <= need_nxt;
			part_r     <= part_nxt;
			two_r      <= two_nxt;
			beats_r    <= beats_nxt;
			narrow_r   <= narrow_nxt;
		end
	end

	// data registers; write data kept across a retry
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wdat_r <= 32'h0;
			whi_r  <= 32'h0;
			acc_r  <= 32'h0;
			dout_r <= 32'h0;
		end else begin
			wdat_r <= wdat_nxt;
			whi_r  <= whi_nxt;
			acc_r  <= acc_nxt;
			dout_r <= dout_nxt;
		end
	end

	// ----------------------------------------
	// pin outputs
	// ----------------------------------------
	wire active = (state_r == bus_seq_pkg::ST_ADDR) || in_xfer || in_burst;
	wire floated = (state_r == bus_seq_pkg::ST_HOLD) ||
	               (state_r == bus_seq_pkg::ST_HALT);

	assign address_out       = addr_r;
	assign address_oe        = !floated;
	assign data_out          = dout_r;
	assign data_oe           = active && is_write && !floated;
	// lanes stay as for a 32-bit bus on every cycle
	assign byte_enable_n     = active ? ~lanes_r : 4'hF;
	assign bus_cycle_start_n = !(state_r == bus_seq_pkg::ST_ADDR);
	assign write_n           = !(active && is_write);
	// burst request shown during transfer states only
	assign burst_request_out_n = !(burst_r && (in_xfer || in_burst));
	assign control_oe        = (state_r != bus_seq_pkg::ST_HOLD);
	assign halted            = (state_r == bus_seq_pkg::ST_HALT);
	assign bus_error_exception = exc_r;

	// status code by cycle kind; halted code held after a fatal error
	assign cycle_status_code =
		halted ? `STATUS_HALTED :
		!active ? `STATUS_IDLE :
		(op_r.kind == bus_seq_pkg::OP_FETCH_NONSEQ) ? `STATUS_FETCH_NONSEQ :
		(op_r.kind == bus_seq_pkg::OP_FETCH_SEQ) ? `STATUS_FETCH_SEQ :
		is_write ? `STATUS_DATA_WRITE : `STATUS_DATA_READ;

endmodule : bus_seq

// ===== logic/bus_seq_defines.svh
// constants of the bus sequencer: width codes, status codes, idle counts
// assumes nothing; included by bare name wherever a figure is needed
`ifndef BUS_SEQ_DEFINES_SVH
`define BUS_SEQ_DEFINES_SVH

// ----------------------------------------
// width-select codes {high, low}
// ----------------------------------------
`define WIDTH_CODE_RSVD        2'h0
`define WIDTH_CODE_8           2'h1
`define WIDTH_CODE_16          2'h2
`define WIDTH_CODE_32          2'h3

// ----------------------------------------
// timing counts in core_clk cycles
// ----------------------------------------
`define NARROW_IDLE_CYCLES     2'h2
`define RETRY_RESTART_CYCLES   2'h2

// ----------------------------------------
// cycle status codes (values arbitrary)
// ----------------------------------------
`define STATUS_IDLE            5'h00
`define STATUS_FETCH_NONSEQ    5'h08
`define STATUS_FETCH_SEQ       5'h09
`define STATUS_DATA_READ       5'h0A
`define STATUS_DATA_WRITE      5'h0B
`define STATUS_HALTED          5'h1F

// ----------------------------------------
// lane and block positions
// ----------------------------------------
`define ALL_LANES              4'hF
`define LAST_DWORD_OF_BLOCK    2'h3
`define BURST_BEATS_MAX        2'h3

`endif

// ===== logic/bus_seq_pkg.sv
// types shared by the bus sequencer and its testbench
// needs no defines header, its figures are literals; holds types only
package bus_seq_pkg;

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,	// no cycle, waiting for an operand
		ST_ADDR  = 3'h1,	// first transfer state, address out
		ST_XFER  = 3'h2,	// second transfer state, repeats as wait state
		ST_BURST = 3'h3,	// extended transfer state, one burst beat
		ST_HOLD  = 3'h4,	// retry held low, bus floated
		ST_GAP   = 3'h5,	// idle states before next cycle
		ST_HALT  = 3'h6	// fatal error, left only by reset
	} seq_state_type;

	// ----------------------------------------
	// operand kinds
	// ----------------------------------------
	typedef enum logic [1:0] {
		OP_FETCH_NONSEQ = 2'h0,
		OP_FETCH_SEQ    = 2'h1,
		OP_READ         = 2'h2,
		OP_WRITE        = 2'h3
	} op_kind_type;

	// operand request from the core side
	typedef struct packed {
		op_kind_type kind;		// fetch or data access
		logic [31:0] addr;		// byte address
		logic [2:0]  size;		// data bytes 1..4, unused for fetch
		logic [31:0] wdata;		// write operand, byte 0 in bits 7:0
		logic        cacheable;	// whole double-word wanted
		logic        needed;	// reference needed to execute
		logic        fatal_ctx;	// exception ack or return read
	} op_req_type;

	// one double-word answer per bus part or burst beat
	typedef struct packed {
		logic [31:0] addr;		// double-word address of the word
		logic [31:0] data;		// lane-aligned data, zero on error
		logic        error;		// bus error seen in this operand
		logic        last;		// final word of the operand
	} op_rsp_type;

	// pin inputs, synchronised as one group
	typedef struct packed {
		logic        retry_n;
		logic        error_n;
		logic        width_high;
		logic        width_low;
		logic        accept_n;
		logic        ready_n;
		logic [31:0] data;
	} bus_in_type;

endpackage : bus_seq_pkg

// ===== logic/word_buffer.sv
// small fifo that holds answer words between the bus and the core
// assumes DEPTH is a power of two and both sides share core_clk
`timescale 1ns/1ps

module word_buffer #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             srst,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_r [DEPTH];	// storage words
	logic [PW-1:0]    wr_r;			// write pointer
	logic [PW-1:0]    rd_r;			// read pointer
	logic [CW-1:0]    cnt_r;		// words held
	logic             push;			// word taken this cycle
	logic             pop;			// word given this cycle

	// ----------------------------------------
	// handshakes: honest full and empty
	// ----------------------------------------
	assign in_ready  = (cnt_r != CW'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rd_r];

	// storage write, no reset needed on data
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end else begin
			wr_r  <= push ? PW'(wr_r + 1'b1) : wr_r;
			rd_r  <= pop ? PW'(rd_r + 1'b1) : rd_r;
			cnt_r <= CW'(cnt_r + CW'(push) - CW'(pop));
		end
	end

endmodule : word_buffer

// ===== dv/bus_seq_monitor.sv
// checker of the sequencer's pin behaviour
// assumes a bind onto every bus_seq instance
`timescale 1ns/1ps
`include "bus_seq_defines.svh"
module bus_seq_monitor (
	// watched ports
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic        halted,
	input wire logic        address_oe,
	input wire logic        data_oe,
	input wire logic        control_oe,
	input wire logic        bus_error_exception,
	input wire logic        bus_cycle_start_n,
	input wire logic [3:0]  byte_enable_n,
	input wire logic [4:0]  cycle_status_code,
	input wire logic [31:0] address_out
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	// float ends: bus driven again after a hold
	sequence float_end;
		!address_oe && !halted ##1 address_oe;
	endsequence
	a_halt_floats: assert property (halted |-> !address_oe && !data_oe
		&& cycle_status_code == `STATUS_HALTED) else $error("halt not floated");
	a_halt_stays: assert property (halted |=> halted) else $error("halt left");
	a_hold_floats: assert property (!address_oe && !halted |-> !control_oe && !data_oe)
		else $error("hold still drives");
	a_retry_gap: assert property (float_end |-> bus_cycle_start_n ##1 bus_cycle_start_n)
		else $error("restart too early");
	a_fetch_lanes: assert property (!bus_cycle_start_n && cycle_status_code inside
		{`STATUS_FETCH_SEQ, `STATUS_FETCH_NONSEQ} |-> byte_enable_n == 4'h0) else $error("lanes");
	a_seq_aligned: assert property (!bus_cycle_start_n && cycle_status_code ==
		`STATUS_FETCH_SEQ |-> address_out[1:0] == 2'h0) else $error("seq fetch unaligned");
	a_start_single: assert property (!bus_cycle_start_n |=> bus_cycle_start_n)
		else $error("start too long");
	a_exc_pulse: assert property (bus_error_exception |=> !bus_error_exception)
		else $error("exception not a pulse");
	a_start_driven: assert property (!bus_cycle_start_n |-> address_oe && control_oe)
		else $error("start while floated");
endmodule : bus_seq_monitor
bind bus_seq bus_seq_monitor bus_seq_monitor_inst (.*);

// ===== dv/bus_mem_model.sv
// memory side model: ready, retry, error, width and data answers
// assumes the testbench sets width code, error, retry and slowness
`timescale 1ns/1ps
`include "bus_seq_defines.svh"
module bus_mem_model (
	// controls and status seen
	input wire logic        core_clk,
	input wire logic [4:0]  cycle_status_code,
	input wire logic [1:0]  width_code,
	input wire logic        err_req,
	input wire logic        rty_req,
	input wire logic        slow,
	// answer pins
	output logic            bus_ready_n,
	output logic            bus_retry_n,
	output logic            bus_error_n,
	output logic            width_select_low,
	output logic            width_select_high,
	output logic            burst_accept_in_n,
	output logic [31:0]     data_in
);
	wire active = cycle_status_code != `STATUS_IDLE;	// a cycle is under way
	assign bus_ready_n = !(active && !slow);			// slow adds wait states
	assign bus_retry_n = !rty_req;						// no slave cycles here
	assign bus_error_n = !err_req;
	assign {width_select_high, width_select_low} = width_code; // changed by the testbench only between operands
	assign burst_accept_in_n = 1'b0;					// bursts always welcome
	assign data_in = active ? 32'hC3A5_5A3C : 32'h3C5A_A5C3; // released bus shows inverse
endmodule : bus_mem_model

// ===== dv/bus_seq_tb_top.sv
// testbench of the bus sequencer with a memory model
// assumes the design and the memory model share core_clk
`timescale 1ns/1ps
`include "bus_seq_defines.svh"
module bus_seq_tb_top;
	logic core_clk = 1'b0, srst = 1'b1, req_valid = 1'b0, rsp_ready = 1'b1;
	logic err_req = 1'b0, rty_req = 1'b0, slow = 1'b0, err_seen;
	logic [1:0] width_code = `WIDTH_CODE_32;
	bus_seq_pkg::op_req_type req = '0;
	bus_seq_pkg::op_rsp_type rsp;
	logic req_ready, rsp_valid, bus_error_exception, halted, address_oe, data_oe, write_n;
	logic control_oe, bus_cycle_start_n, burst_request_out_n, bus_ready_n, bus_retry_n;
	logic bus_error_n, width_select_low, width_select_high, burst_accept_in_n;
	logic [31:0] address_out, data_out, data_in, a0;
	logic [3:0] byte_enable_n;
	logic [4:0] cycle_status_code;
	int n_mismatch = 0, check_count = 0, n_words, n_starts, n_exc, stall = 0;
	bus_seq bus_seq_inst (.*);
	bus_mem_model bus_mem_model_inst (.*);
	always #4 core_clk = ~core_clk;
	// cycle starts and exceptions per operand; core stalls while stall runs
	always @(posedge core_clk) begin
		n_starts += !bus_cycle_start_n;
		n_exc += bus_error_exception;
		rsp_ready <= stall == 0;
		if (stall > 0) stall <= stall - 1;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	// one operand: offer, then collect words until last or halt
	task op(input bus_seq_pkg::op_kind_type k, input logic [31:0] a, input logic [2:0] fl);
		int i;
		n_words = 0; n_starts = 0; n_exc = 0; err_seen = 1'b0;
		@(posedge core_clk);
		req <= '{k, a, 3'h4, 32'h1122_3344, fl[2], fl[1], fl[0]};
		req_valid <= 1'b1;
		for (i = 0; i < 400; i++) begin
			@(negedge core_clk);
			if (req_valid && req_ready) begin
				@(posedge core_clk);
				req_valid <= 1'b0;
			end else if (rsp_valid && rsp_ready) begin
				if (n_words == 0) a0 = rsp.addr;
				n_words++;
				err_seen |= rsp.error;
				if (rsp.last) break;
			end else if (halted) break;
		end
		if (i == 400) begin n_mismatch++; finish_test(); end
		repeat (3) @(negedge core_clk);
	endtask : op
	task t_fetch;
		op(bus_seq_pkg::OP_FETCH_SEQ, 32'h4, 3'h0);
		chk(n_words, 3);
		chk(a0, 32'h4);
		chk(n_starts, 1);
		$display("fetch burst done");
	endtask : t_fetch
	task t_width;
		for (int w = 0; w < 4; w++) begin
			@(posedge core_clk);
			width_code <= 2'(w);
			op(bus_seq_pkg::OP_FETCH_NONSEQ, 32'h4C, 3'h4);
			chk(n_starts, w == 1 ? 4 : w == 2 ? 2 : 1);
			chk(n_words, 1);
		end
		@(posedge core_clk);
		width_code <= `WIDTH_CODE_32;
		$display("widths done");
	endtask : t_width
	task t_retry;
		@(posedge core_clk);
		rty_req <= 1'b1;
		err_req <= 1'b1;
		fork
			op(bus_seq_pkg::OP_READ, 32'h60, 3'h2);
			begin repeat (12) @(posedge core_clk); rty_req <= 1'b0; err_req <= 1'b0; end
		join
		chk(n_starts, 2);
		chk(a0, 32'h60);
		chk({err_seen, 4'(n_exc)}, 0);
		$display("retry done");
	endtask : t_retry
	task t_error;
		@(posedge core_clk);
		slow <= 1'b1;
		err_req <= 1'b1;
		fork
			op(bus_seq_pkg::OP_READ, 32'h70, 3'h2);
			begin repeat (6) @(posedge core_clk); err_req <= 1'b0; @(posedge core_clk); slow <= 1'b0; end
		join
		chk(err_seen, 0);
		@(posedge core_clk);
		err_req <= 1'b1;
		stall <= 12;
		op(bus_seq_pkg::OP_READ, 32'h2E, 3'h2);
		chk(n_words, 2);
		chk(a0, 32'h2C);
		chk({err_seen, 4'(n_exc)}, 5'h11);
		op(bus_seq_pkg::OP_READ, 32'h50, 3'h3);
		chk(halted, 1);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		chk(halted, 0);
		$display("errors and halt done");
	endtask : t_error
	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		t_fetch();
		t_width();
		t_retry();
		t_error();
		finish_test();
	end
endmodule : bus_seq_tb_top
